// ---- rtl/iobpc_top.sv ----
`timescale 1ns/1ps
module iobpc_top
  import iobpc_pkg::*;
(
  // system
  input wire logic CLOCK,
  input wire logic RESETN,
  // bus reset line and master clock
  input wire logic BUS_RESET_N,
  input wire logic MASTER_CLOCK,
  output logic PHASE_A_OUT,
  output logic PHASE_B_OUT,
  output logic BUS_IN_RESET,
  // user requests and acknowledge
  input wire iobpc_pkg::iobpc_chain_type REQUEST,
  input wire iobpc_pkg::iobpc_chain_type ACK,
  output iobpc_pkg::iobpc_chain_type RESPOND,
  // priority chains
  input wire iobpc_pkg::iobpc_chain_type PRIORITY_IN,
  output iobpc_pkg::iobpc_chain_type PRIORITY_OUT,
  output iobpc_pkg::iobpc_chain_type REQUEST_LINE_N,
  // serial link receive: strobe-domain inputs, word out on CLOCK
  input wire logic IO_STROBE_IN,
  input wire iobpc_pkg::iobpc_serial_type IO_DATA_IN,
  output logic RX_VALID,
  output logic [2*WORD_BITS-1:0] RX_WORD,
  // transmit side
  input wire logic TX_START,
  input wire logic [2*WORD_BITS-1:0] TX_WORD,
  output logic TX_BUSY,
  output logic IO_STROBE_OUT,
  output iobpc_pkg::iobpc_serial_type IO_DATA_OUT,
  output logic IO_DATA_OE,
  output logic XCVR_TRANSMIT
);
  import iobpc_pkg::*;

  function automatic logic [1:0] sync2(input logic [1:0] s, input logic d);
    sync2 = {s[0], d};
  endfunction

  // bus reset qualification
  logic [1:0] busrst_sync_reg;
  logic [RESET_CNT_W-1:0] busrst_cnt_reg;
  logic bus_in_reset_reg;

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
      busrst_sync_reg <= 2'h3;
    else
      busrst_sync_reg <= sync2(busrst_sync_reg, BUS_RESET_N);

  // a short glitch does not reset; only a low held the full time
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      busrst_cnt_reg <= '0;
      bus_in_reset_reg <= 1'b0;
    end
    else if (busrst_sync_reg[1])
    begin
      busrst_cnt_reg <= '0;
      bus_in_reset_reg <= 1'b0;
    end
    else if (busrst_cnt_reg == RESET_CNT_W'(RESET_LOW_CYCLES - 1))
      bus_in_reset_reg <= 1'b1;
    else
      busrst_cnt_reg <= busrst_cnt_reg + 1'b1;

  // any low level forces receive mode, reset or not
  logic bus_low;
  assign bus_low = ~busrst_sync_reg[1];
  logic sys_reset;
  assign sys_reset = bus_in_reset_reg;

  // master clock phases
  logic [1:0] mclk_sync_reg;
  logic mclk_prev_reg;
  logic [PHASE_CNT_W-1:0] phase_cnt_reg;
  logic phase_a_reg;
  logic phase_b_reg;

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      mclk_sync_reg <= 2'h0;
      mclk_prev_reg <= 1'b0;
    end
    else
    begin
      mclk_sync_reg <= sync2(mclk_sync_reg, MASTER_CLOCK);
      mclk_prev_reg <= mclk_sync_reg[1];
    end

  // one dead slot between phases keeps them from overlapping
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      phase_cnt_reg <= '0;
      phase_a_reg <= 1'b0;
      phase_b_reg <= 1'b0;
    end
    else
    begin
      if (mclk_sync_reg[1] != mclk_prev_reg)
        phase_cnt_reg <= phase_cnt_reg + 1'b1;
      phase_a_reg <= (phase_cnt_reg == PHASE_A) && !phase_b_reg;
      phase_b_reg <= (phase_cnt_reg == PHASE_B) && !phase_a_reg;
    end

  // priority chains
  logic [1:0] pin_irq_sync_reg;
  logic [1:0] pin_blk_sync_reg;
  iobpc_chain_type pin;
  iobpc_chain_type pend_reg;
  iobpc_chain_type pout_reg;
  iobpc_chain_type respond_reg;
  iobpc_chain_type req_line_n_reg;

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      // idle high, so priority is not briefly lost after reset
      pin_irq_sync_reg <= 2'h3;
      pin_blk_sync_reg <= 2'h3;
    end
    else
    begin
      pin_irq_sync_reg <= sync2(pin_irq_sync_reg, PRIORITY_IN.irq);
      pin_blk_sync_reg <= sync2(pin_blk_sync_reg, PRIORITY_IN.blk);
    end

  assign pin.irq = pin_irq_sync_reg[1];
  assign pin.blk = pin_blk_sync_reg[1];

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
      pend_reg <= '0;
    else if (sys_reset)
      pend_reg <= '0;
    else
      pend_reg <= REQUEST;

  // same mechanism on both chains
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
      pout_reg <= '1;
    else if (sys_reset)
      pout_reg <= '1;
    else
    begin
      pout_reg.irq <= pend_reg.irq ? 1'b0 : pin.irq;
      pout_reg.blk <= pend_reg.blk ? 1'b0 : pin.blk;
    end

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
      req_line_n_reg <= '1;
    else if (sys_reset)
      req_line_n_reg <= '1;
    else
      req_line_n_reg <= ~pend_reg;

  // nearest requester wins since farther ones see low input
  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
      respond_reg <= '0;
    else if (sys_reset)
      respond_reg <= '0;
    else
      respond_reg <= ACK & pend_reg & pin;

  // strobe-domain receiver
  logic [1:0] srst_sync_reg;
  logic [BIT_CNT_W-1:0] rx_cnt_reg;
  logic [WORD_BITS-1:0] rx_sh1_reg;
  logic [WORD_BITS-1:0] rx_sh2_reg;
  logic [2*WORD_BITS-1:0] rx_hold_reg;
  logic rx_tog_reg;

  always_ff @(posedge IO_STROBE_IN or negedge RESETN)
    if (!RESETN)
      srst_sync_reg <= 2'h0;
    else
      srst_sync_reg <= sync2(srst_sync_reg, 1'b1);

  // bit count wraps on the word; strobe need not run between words
  always_ff @(posedge IO_STROBE_IN or negedge RESETN)
    if (!RESETN)
    begin
      rx_cnt_reg <= '0;
      rx_sh1_reg <= '0;
      rx_sh2_reg <= '0;
      rx_hold_reg <= '0;
      rx_tog_reg <= 1'b0;
    end
    else if (srst_sync_reg[1])
    begin
      rx_sh1_reg <= {rx_sh1_reg[WORD_BITS-2:0], IO_DATA_IN.d1};
      rx_sh2_reg <= {rx_sh2_reg[WORD_BITS-2:0], IO_DATA_IN.d2};
      if (rx_cnt_reg == BIT_CNT_W'(WORD_BITS - 1))
      begin
        rx_cnt_reg <= '0;
        rx_hold_reg <= {rx_sh1_reg[WORD_BITS-2:0], IO_DATA_IN.d1, rx_sh2_reg[WORD_BITS-2:0], IO_DATA_IN.d2};
        rx_tog_reg <= ~rx_tog_reg;
      end
      else
        rx_cnt_reg <= rx_cnt_reg + 1'b1;
    end

  // word is stable for many strobe cycles after the toggle
  logic [1:0] rx_tog_sync_reg;
  logic rx_tog_seen_reg;
  logic rx_valid_reg;
  logic [2*WORD_BITS-1:0] rx_word_reg;

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      rx_tog_sync_reg <= 2'h0;
      rx_tog_seen_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_word_reg <= '0;
    end
    else
    begin
      rx_tog_sync_reg <= sync2(rx_tog_sync_reg, rx_tog_reg);
      rx_tog_seen_reg <= rx_tog_sync_reg[1];
      rx_valid_reg <= rx_tog_sync_reg[1] != rx_tog_seen_reg;
      if (rx_tog_sync_reg[1] != rx_tog_seen_reg)
        rx_word_reg <= rx_hold_reg;
    end

  // transmitter, strobe made from CLOCK by halving
  iobpc_tx_state_type tx_state_reg;
  logic [BIT_CNT_W-1:0] tx_cnt_reg;
  logic [2*WORD_BITS-1:0] tx_sh_reg;
  logic tx_strobe_reg;
  logic xmit_reg;

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
    begin
      tx_state_reg <= IOBPC_IDLE;
      tx_cnt_reg <= '0;
      tx_sh_reg <= '0;
      tx_strobe_reg <= 1'b0;
    end
    else if (bus_low)
    begin
      tx_state_reg <= IOBPC_IDLE;
      tx_strobe_reg <= 1'b0;
    end
    else
      case (tx_state_reg)
        IOBPC_IDLE:
          if (TX_START)
          begin
            tx_sh_reg <= TX_WORD;
            tx_cnt_reg <= '0;
            tx_state_reg <= IOBPC_SEND;
          end
        IOBPC_SEND:
        begin
          tx_strobe_reg <= ~tx_strobe_reg;
          if (tx_strobe_reg)
          begin
            tx_sh_reg <= {tx_sh_reg[2*WORD_BITS-2:WORD_BITS], 1'b0, tx_sh_reg[WORD_BITS-2:0], 1'b0};
            if (tx_cnt_reg == BIT_CNT_W'(WORD_BITS - 1))
              tx_state_reg <= IOBPC_DONE;
            else
              tx_cnt_reg <= tx_cnt_reg + 1'b1;
          end
        end
        IOBPC_DONE:
          tx_state_reg <= IOBPC_IDLE;
        default:
          tx_state_reg <= IOBPC_IDLE;
      endcase

  always_ff @(posedge CLOCK or negedge RESETN)
    if (!RESETN)
      xmit_reg <= 1'b0;
    else
      xmit_reg <= !bus_low && (tx_state_reg == IOBPC_SEND || (tx_state_reg == IOBPC_IDLE && TX_START));

  assign PHASE_A_OUT = phase_a_reg;
  assign PHASE_B_OUT = phase_b_reg;
  assign BUS_IN_RESET = bus_in_reset_reg;
  assign RESPOND = respond_reg;
  assign PRIORITY_OUT = pout_reg;
  assign REQUEST_LINE_N = req_line_n_reg;
  assign RX_VALID = rx_valid_reg;
  assign RX_WORD = rx_word_reg;
  assign TX_BUSY = xmit_reg;
  assign IO_STROBE_OUT = tx_strobe_reg;
  assign IO_DATA_OUT.d1 = tx_sh_reg[2*WORD_BITS-1];
  assign IO_DATA_OUT.d2 = tx_sh_reg[WORD_BITS-1];
  assign IO_DATA_OE = xmit_reg;
  assign XCVR_TRANSMIT = xmit_reg;

  // checks
  AST_NO_DRIVE_IN_RESET: assert property (@(posedge CLOCK) disable iff (!RESETN)
    bus_low |=> !xmit_reg) else $error("transceiver drives while bus reset low");
  AST_RESET_AFTER_HOLD: assert property (@(posedge CLOCK) disable iff (!RESETN)
    bus_in_reset_reg |-> !$past(busrst_sync_reg[1])) else $error("reset flagged with line high");
  AST_PRIO_LOW_ON_REQ: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (pend_reg.irq && !sys_reset) |=> !pout_reg.irq) else $error("irq output not low on request");
  AST_PRIO_PASS_BLK: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (!pend_reg.blk && !sys_reset) |=> pout_reg.blk == $past(pin.blk)) else $error("blk chain not passed");
  AST_RESPOND_GATED: assert property (@(posedge CLOCK) disable iff (!RESETN)
    respond_reg.irq |-> $past(pin.irq) && $past(pend_reg.irq)) else $error("respond without priority");
  sequence s_withdraw;
    pend_reg.blk ##1 !pend_reg.blk && pin.blk && !sys_reset;
  endsequence
  AST_RELEASE: assert property (@(posedge CLOCK) disable iff (!RESETN)
    s_withdraw |=> pout_reg.blk) else $error("priority not released");
  AST_PHASE_NONOVL: assert property (@(posedge CLOCK) disable iff (!RESETN)
    !(phase_a_reg && phase_b_reg)) else $error("phases overlap");
  AST_DIR_MATCH_OE: assert property (@(posedge CLOCK) disable iff (!RESETN)
    tx_state_reg == IOBPC_SEND && !bus_low |=> xmit_reg) else $error("direction not transmit");
endmodule

// ---- shared/iobpc_pkg.sv ----
package iobpc_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESET_LOW_TIME_US = 10;
  localparam int RESET_LOW_CYCLES = (RESET_LOW_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_CNT_W = 14;
  localparam int MAX_POSITIONS = 20;
  localparam int WORD_BITS = 9;
  localparam int BIT_CNT_W = 4;
  localparam int PHASE_CNT_W = 2;
  localparam logic [1:0] PHASE_A = 2'h0;
  localparam logic [1:0] PHASE_B = 2'h2;

  typedef struct packed {
    logic irq;
    logic blk;
  } iobpc_chain_type;

  typedef struct packed {
    logic d1;
    logic d2;
  } iobpc_serial_type;

  typedef enum logic [1:0] {
    IOBPC_IDLE = 2'b00,
    IOBPC_SEND = 2'b01,
    IOBPC_DONE = 2'b10
  } iobpc_tx_state_type;
endpackage

// ---- verif/iobpc_far_end.sv ----
`timescale 1ns/1ps
module iobpc_far_end
(
  // nearer controller
  input wire iobpc_pkg::iobpc_chain_type near_req,
  output iobpc_pkg::iobpc_chain_type prio_in,
  // processor transmit side
  output logic strobe,
  output iobpc_pkg::iobpc_serial_type data
);
  import iobpc_pkg::*;
  // nearest slot: a request pulls low, otherwise the processor's high passes
  assign prio_in = ~near_req;
  initial
  begin
    strobe = 1'h0;
    data = 2'h0;
  end
  // the strobe-side reset of the block eats two edges before framing starts
  // start off the system clock edges so the two domains do not line up
  task automatic wake();
    #1;
    repeat (2)
    begin
      #6 strobe = 1'h1;
      #6 strobe = 1'h0;
    end
  endtask
  // slow_ns stretches each low half to model a sluggish sender
  task automatic send_word(input logic [2*WORD_BITS-1:0] w, input int slow_ns);
    #1;
    for (int i = WORD_BITS - 1; i >= 0; i--)
    begin
      data = {w[WORD_BITS + i], w[i]};
      #(6 + slow_ns) strobe = 1'h1;
      #6 strobe = 1'h0;
    end
    // line released: show the inverse so a stale bit never looks valid
    data = ~data;
  endtask
endmodule

// ---- verif/iobpc_top_tb.sv ----
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module iobpc_top_tb;
  import iobpc_pkg::*;
  logic clock, resetn, bus_reset_n, master_clock, phase_a, phase_b, bus_in_reset;
  logic rx_valid, tx_start, tx_busy, strobe_out, data_oe, xcvr_tx, strobe_in;
  logic [2*WORD_BITS-1:0] rx_word, tx_word;
  iobpc_chain_type request, ack, respond, prio_in, prio_out, req_line_n, near_req;
  iobpc_serial_type data_in, data_out;
  int n_errors = 0;
  int total_checks = 0;
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  iobpc_top dut (.CLOCK(clock), .RESETN(resetn), .BUS_RESET_N(bus_reset_n), .MASTER_CLOCK(master_clock),
    .PHASE_A_OUT(phase_a), .PHASE_B_OUT(phase_b), .BUS_IN_RESET(bus_in_reset), .REQUEST(request),
    .ACK(ack), .RESPOND(respond), .PRIORITY_IN(prio_in), .PRIORITY_OUT(prio_out),
    .REQUEST_LINE_N(req_line_n), .IO_STROBE_IN(strobe_in), .IO_DATA_IN(data_in), .RX_VALID(rx_valid),
    .RX_WORD(rx_word), .TX_START(tx_start), .TX_WORD(tx_word), .TX_BUSY(tx_busy),
    .IO_STROBE_OUT(strobe_out), .IO_DATA_OUT(data_out), .IO_DATA_OE(data_oe), .XCVR_TRANSMIT(xcvr_tx));
  iobpc_far_end far (.near_req(near_req), .prio_in(prio_in), .strobe(strobe_in), .data(data_in));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic give_up();
    n_errors++;
    report_and_stop();
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask
  // c selects the chain bit: 1 interrupt, 0 block transfer
  task automatic chain_case(input int c);
    request[c] = 1'h1;
    cycles(4);
    `CHECK("prio_out", 1'h0, prio_out[c])
    `CHECK("req_line_n", 2'h3 ^ (2'h1 << c), req_line_n)
    `CHECK("other chain", 1'h1, prio_out[1-c])
    ack[c] = 1'h1;
    cycles(4);
    `CHECK("respond", 2'h1 << c, respond)
    near_req[c] = 1'h1;
    cycles(5);
    `CHECK("respond nearer", 2'h0, respond)
    request[c] = 1'h0;
    cycles(5);
    `CHECK("pass low", 1'h0, prio_out[c])
    near_req[c] = 1'h0;
    cycles(5);
    `CHECK("pass high", 2'h3, prio_out)
    request[c] = 1'h1;
    cycles(4);
    `CHECK("respond again", 2'h1 << c, respond)
    request[c] = 1'h0;
    cycles(3);
    `CHECK("release", 2'h3, prio_out)
    `CHECK("respond dropped", 2'h0, respond)
    ack[c] = 1'h0;
  endtask
  task automatic rx_case(input logic [2*WORD_BITS-1:0] w, input int slow);
    int k;
    far.send_word(w, slow);
    for (k = 0; k < 40 && rx_valid !== 1'h1; k++)
      cycles(1);
    if (k == 40)
      give_up();
    `CHECK("rx_word", w, rx_word)
    cycles(4);
  endtask
  task automatic tx_case(input logic [2*WORD_BITS-1:0] w);
    logic [2*WORD_BITS-1:0] got;
    logic last;
    int n;
    int k;
    got = '0;
    last = 1'h0;
    n = 0;
    tx_word = w;
    tx_start = 1'h1;
    cycles(1);
    tx_start = 1'h0;
    `CHECK("transmit dir", 2'h3, {xcvr_tx, data_oe})
    for (k = 0; k < 60 && tx_busy === 1'h1; k++)
    begin
      if (strobe_out === 1'h1 && last === 1'h0)
      begin
        got = {got[16:9], data_out.d1, got[7:0], data_out.d2};
        n++;
      end
      last = strobe_out;
      cycles(1);
    end
    if (k == 60)
      give_up();
    `CHECK("tx bits", 9, n)
    `CHECK("tx word", w, got)
    cycles(2);
    `CHECK("receive dir", 2'h0, {xcvr_tx, data_oe})
  endtask
  task automatic phase_case();
    int seen_a;
    int seen_b;
    seen_a = 0;
    seen_b = 0;
    repeat (16)
    begin
      master_clock = ~master_clock;
      repeat (15)
      begin
        cycles(1);
        `CHECK("phase overlap", 1'h0, phase_a & phase_b)
        seen_a += int'(phase_a);
        seen_b += int'(phase_b);
      end
    end
    `CHECK("phases run", 2'h3, {seen_a > 0, seen_b > 0})
  endtask
  task automatic bus_reset_case();
    tx_word = 18'h2AAAA;
    tx_start = 1'h1;
    cycles(1);
    tx_start = 1'h0;
    cycles(5);
    bus_reset_n = 1'h0;
    cycles(4);
    `CHECK("drive in reset", 2'h0, {xcvr_tx, data_oe})
    tx_start = 1'h1;
    cycles(1);
    tx_start = 1'h0;
    request = 2'h3;
    ack = 2'h3;
    cycles(2);
    `CHECK("start refused", 1'h0, tx_busy)
    cycles(2472);
    `CHECK("reset too early", 1'h0, bus_in_reset)
    cycles(30);
    `CHECK("reset seen", 1'h1, bus_in_reset)
    `CHECK("chains cleared", 4'hC, {prio_out, respond})
  endtask
  initial
  begin
    resetn = 1'h0;
    bus_reset_n = 1'h1;
    master_clock = 1'h0;
    tx_start = 1'h0;
    tx_word = '0;
    request = 2'h0;
    ack = 2'h0;
    near_req = 2'h0;
    cycles(10);
    resetn = 1'h1;
    far.wake();
    cycles(4);
    chain_case(1);
    chain_case(0);
    rx_case(18'h3FE01, 0);
    rx_case(18'h00155, 0);
    rx_case(18'h2AB54, 20);
    tx_case(18'h3C0F1);
    tx_case(18'h0003F);
    phase_case();
    bus_reset_case();
    report_and_stop();
  end
endmodule
